// ---- hdl/crs_regs.svh ----
// register and stack constants for the core register set
`ifndef CRS_REGS_SVH
`define CRS_REGS_SVH
`define CRS_SP_RESET      16'h01FF
`define CRS_SP_FORCED     9'h003
`define CRS_SP_LOW_TOP    7'h7F
`define CRS_SP_LOW_ONE    7'h01
`define CRS_ZERO8         8'h00
`define CRS_ZERO16        16'h0000
`define CRS_CALL_BYTES    3'h2
`define CRS_INT_BYTES     3'h5
`define CRS_STEP_ONE      3'h1
`define CRS_STEP_ZERO     3'h0
`define CRS_SLOT_PCL      3'h0
`define CRS_SLOT_PCH      3'h1
`define CRS_SLOT_X        3'h2
`define CRS_SLOT_A        3'h3
`define CRS_SLOT_CC       3'h4
`endif

// ---- hdl/crs_pkg.sv ----
// types for the core register set
package crs_pkg;
   typedef enum logic [6:0] {
      CRS_OP_NONE    = 7'b000_0001,
      CRS_OP_PUSH    = 7'b000_0010,
      CRS_OP_POP     = 7'b000_0100,
      CRS_OP_CALL    = 7'b000_1000,
      CRS_OP_RET     = 7'b001_0000,
      CRS_OP_INT     = 7'b010_0000,
      CRS_OP_IRET    = 7'b100_0000
   } crs_op_type;
   typedef enum logic [2:0] {
      CRS_ST_IDLE = 3'b001,
      CRS_ST_PUSH = 3'b010,
      CRS_ST_POP  = 3'b100
   } crs_state_type;
   typedef struct packed {
      logic [7:0]  acc;
      logic [7:0]  idx_x;
      logic [7:0]  idx_y;
      logic [7:0]  count_high_byte;
      logic [7:0]  count_low_byte;
      logic [15:0] stack_top_pointer;
   } crs_regs_type;
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } crs_mem_type;
endpackage

// ---- hdl/crs_core_regs.sv ----
// core register set with stack pointer and stack sequencer
`timescale 1ns/1ps
`default_nettype none
`include "crs_regs.svh"
//////////////////////////////////////////////////////////////////////////////
module crs_core_regs
   import crs_pkg::*;
(
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire crs_op_type   stack_op,
   input  wire logic [7:0]   push_data,
   input  wire logic         stack_reinit_op,
   input  wire logic         acc_we,
   input  wire logic [7:0]   acc_wdata,
   input  wire logic         idx_we,
   input  wire logic         prefix_sel,
   input  wire logic [7:0]   idx_wdata,
   input  wire logic         pc_we,
   input  wire logic [15:0]  pc_wdata,
   input  wire logic         sp_low_we,
   input  wire logic [7:0]   sp_low_wdata,
   input  wire logic [7:0]   cc_in,
   input  wire logic [7:0]   mem_rdata,
   output crs_regs_type      regs,
   output logic [7:0]        idx_sel,
   output logic [7:0]        sp_low_byte,
   output crs_mem_type       mem,
   output logic [7:0]        pop_data,
   output logic              pop_valid,
   output logic [7:0]        cc_out,
   output logic              cc_valid,
   output logic              busy
);
   //////////////////////////////////////////////////////////////////////////
   // state
   crs_state_type state;
   crs_state_type next_state;
   logic [2:0]    remain;
   logic [2:0]    next_remain;
   logic [2:0]    slot;
   logic [2:0]    next_slot;
   logic          frame;
   logic          next_frame;
   logic          plain;
   logic          next_plain;
   logic          rq_pend;
   logic          rq_plain;
   logic [2:0]    rq_slot;
   logic          rq_frame;
   logic          rd_pend;
   logic          rd_plain;
   logic [2:0]    rd_slot;
   logic          rd_frame;

   // stack address with forced upper bits
   function automatic logic [15:0] sp_form(input logic [6:0] low);
      sp_form = {`CRS_SP_FORCED, low};
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // decode of requested operation
   wire logic       op_push  = (stack_op == CRS_OP_PUSH)
                               || (stack_op == CRS_OP_CALL)
                               || (stack_op == CRS_OP_INT);
   wire logic       op_pop   = (stack_op == CRS_OP_POP)
                               || (stack_op == CRS_OP_RET)
                               || (stack_op == CRS_OP_IRET);
   wire logic       op_frame = (stack_op == CRS_OP_INT)
                               || (stack_op == CRS_OP_IRET);
   wire logic [2:0] op_len   =
      op_frame ? `CRS_INT_BYTES :
      ((stack_op == CRS_OP_CALL) || (stack_op == CRS_OP_RET))
         ? `CRS_CALL_BYTES : `CRS_STEP_ONE;
   wire logic       start    = (state == CRS_ST_IDLE) && (op_push || op_pop)
                               && !stack_reinit_op;
   wire logic [6:0] sp_low   = regs.stack_top_pointer[6:0];
   // wrap within seven bits, no overflow flag
   wire logic [6:0] sp_dec   = sp_low - `CRS_SP_LOW_ONE;
   wire logic [6:0] sp_inc   = sp_low + `CRS_SP_LOW_ONE;
   wire logic       in_push  = (state == CRS_ST_PUSH);
   wire logic       in_pop   = (state == CRS_ST_POP);
   wire logic       last     = (remain == `CRS_STEP_ONE);

   // byte sent on push: frame order pcl, pch, x, a, cc
   wire logic [7:0] push_byte =
      !frame ? ((slot == `CRS_SLOT_PCL) && (remain != `CRS_STEP_ONE)
                || (remain == `CRS_CALL_BYTES)
                ? regs.count_low_byte
                : (slot == `CRS_SLOT_PCH) ? regs.count_high_byte
                : push_data) :
      (slot == `CRS_SLOT_PCL) ? regs.count_low_byte :
      (slot == `CRS_SLOT_PCH) ? regs.count_high_byte :
      (slot == `CRS_SLOT_X)   ? regs.idx_x :
      (slot == `CRS_SLOT_A)   ? regs.acc : cc_in;

   //////////////////////////////////////////////////////////////////////////
   // sequencer next state
   always_comb begin
      next_state  = state;
      next_remain = remain;
      next_slot   = slot;
      next_frame  = frame;
      next_plain  = plain;
      case (state)
         CRS_ST_IDLE: begin
            if (start) begin
               next_remain = op_len;
               next_frame  = op_frame;
               // single-byte push or pop touches no core register
               next_plain  = (op_len == `CRS_STEP_ONE);
               // pop frames start from the innermost slot
               next_slot   = op_pop ? op_len - `CRS_STEP_ONE
                                    : `CRS_SLOT_PCL;
               next_state  = op_push ? CRS_ST_PUSH : CRS_ST_POP;
            end
         end
         CRS_ST_PUSH: begin
            next_slot   = slot + `CRS_STEP_ONE;
            next_remain = remain - `CRS_STEP_ONE;
            if (last) begin
               next_state = CRS_ST_IDLE;
            end
         end
         CRS_ST_POP: begin
            next_slot   = slot - `CRS_STEP_ONE;
            next_remain = remain - `CRS_STEP_ONE;
            if (last) begin
               next_state = CRS_ST_IDLE;
            end
         end
         default: begin
            next_state  = CRS_ST_IDLE;
            next_remain = `CRS_STEP_ZERO;
            next_slot   = `CRS_STEP_ZERO;
            next_frame  = 1'b0;
            next_plain  = 1'b0;
         end
      endcase
   end

   //////////////////////////////////////////////////////////////////////////
   // sequencer registers
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state  <= CRS_ST_IDLE;
         remain <= `CRS_STEP_ZERO;
         slot   <= `CRS_STEP_ZERO;
         frame  <= 1'b0;
         plain  <= 1'b0;
      end else begin
         state  <= next_state;
         remain <= next_remain;
         slot   <= next_slot;
         frame  <= next_frame;
         plain  <= next_plain;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // stack pointer: write at pointer then decrement, increment then read
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         regs.stack_top_pointer <= `CRS_SP_RESET;
      end else if (stack_reinit_op) begin
         regs.stack_top_pointer <= `CRS_SP_RESET;
      end else if (in_push) begin
         regs.stack_top_pointer <= sp_form(sp_dec);
      end else if (in_pop) begin
         regs.stack_top_pointer <= sp_form(sp_inc);
      end else if (sp_low_we) begin
         regs.stack_top_pointer <= sp_form(sp_low_wdata[6:0]);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // memory strobes; push address is the free slot itself
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         mem <= '0;
      end else begin
         mem.wr    <= in_push;
         mem.rd    <= in_pop;
         mem.addr  <= in_push ? sp_form(sp_low)
                    : in_pop  ? sp_form(sp_inc) : `CRS_ZERO16;
         mem.wdata <= in_push ? push_byte : `CRS_ZERO8;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // read tracking: data returns the cycle after mem.rd, so the slot
   // travels two stages to meet it; plain pops load no register
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rq_pend  <= 1'b0;
         rq_plain <= 1'b0;
         rq_slot  <= `CRS_STEP_ZERO;
         rq_frame <= 1'b0;
         rd_pend  <= 1'b0;
         rd_plain <= 1'b0;
         rd_slot  <= `CRS_STEP_ZERO;
         rd_frame <= 1'b0;
      end else begin
         rq_pend  <= in_pop && !plain;
         rq_plain <= in_pop && plain;
         rq_slot  <= slot;
         rq_frame <= frame;
         rd_pend  <= rq_pend;
         rd_plain <= rq_plain;
         rd_slot  <= rq_slot;
         rd_frame <= rq_frame;
      end
   end

   wire logic rd_ret   = rd_pend;
   wire logic ld_pcl   = rd_ret && (rd_slot == `CRS_SLOT_PCL);
   wire logic ld_pch   = rd_ret && (rd_slot == `CRS_SLOT_PCH);
   wire logic ld_x     = rd_ret && rd_frame && (rd_slot == `CRS_SLOT_X);
   wire logic ld_a     = rd_ret && rd_frame && (rd_slot == `CRS_SLOT_A);
   wire logic ld_cc    = rd_ret && rd_frame && (rd_slot == `CRS_SLOT_CC);

   //////////////////////////////////////////////////////////////////////////
   // accumulator and index registers, y never in a frame
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         regs.acc   <= `CRS_ZERO8;
         regs.idx_x <= `CRS_ZERO8;
         regs.idx_y <= `CRS_ZERO8;
      end else begin
         if (ld_a) begin
            regs.acc <= mem_rdata;
         end else if (acc_we) begin
            regs.acc <= acc_wdata;
         end
         if (ld_x) begin
            regs.idx_x <= mem_rdata;
         end else if (idx_we && !prefix_sel) begin
            regs.idx_x <= idx_wdata;
         end
         if (idx_we && prefix_sel) begin
            regs.idx_y <= idx_wdata;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // program counter halves
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         regs.count_high_byte <= `CRS_ZERO8;
         regs.count_low_byte  <= `CRS_ZERO8;
      end else begin
         if (ld_pch) begin
            regs.count_high_byte <= mem_rdata;
         end else if (pc_we) begin
            regs.count_high_byte <= pc_wdata[15:8];
         end
         if (ld_pcl) begin
            regs.count_low_byte <= mem_rdata;
         end else if (pc_we) begin
            regs.count_low_byte <= pc_wdata[7:0];
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // side outputs, all registered
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         idx_sel     <= `CRS_ZERO8;
         sp_low_byte <= `CRS_ZERO8;
         pop_data    <= `CRS_ZERO8;
         pop_valid   <= 1'b0;
         cc_out      <= `CRS_ZERO8;
         cc_valid    <= 1'b0;
         busy        <= 1'b0;
      end else begin
         idx_sel     <= prefix_sel ? regs.idx_y : regs.idx_x;
         sp_low_byte <= regs.stack_top_pointer[7:0];
         pop_data    <= rd_plain ? mem_rdata : pop_data;
         pop_valid   <= rd_plain;
         cc_out      <= ld_cc ? mem_rdata : cc_out;
         cc_valid    <= ld_cc;
         busy        <= (next_state != CRS_ST_IDLE);
      end
   end
endmodule
`default_nettype wire

// ---- verif/crs_mem_model.sv ----
// data memory model standing behind the stack port
`timescale 1ns/1ps
`default_nettype none
module crs_mem_model
   import crs_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire crs_mem_type mem,
   output var  logic [7:0]  mem_rdata
);
   logic [7:0] ram [0:511];
   initial mem_rdata = 8'h00;
   // write on strobe; read one cycle late, else a changing idle pattern
   always @(posedge ref_clk) begin
      if (mem.wr)
         ram[mem.addr[8:0]] <= mem.wdata;
      mem_rdata <= mem.rd ? ram[mem.addr[8:0]] : ~mem_rdata;
   end
endmodule
`default_nettype wire

// ---- verif/crs_core_regs_checker.sv ----
// stack and register assertions for the core register set
`timescale 1ns/1ps
`default_nettype none
module crs_checker
   import crs_pkg::*;
(
   input wire logic         ref_clk,
   input wire logic         rst_n,
   input wire crs_op_type   stack_op,
   input wire logic         stack_reinit_op,
   input wire logic         idx_we,
   input wire logic         prefix_sel,
   input wire crs_regs_type regs,
   input wire logic [7:0]   idx_sel,
   input wire crs_mem_type  mem,
   input wire logic         busy
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire logic [15:0] sp = regs.stack_top_pointer;
   // accepted start of a sequence and its byte bursts
   sequence s_go(o);
      stack_op == o && !busy && !stack_reinit_op;
   endsequence
   sequence s_wr5;
      mem.wr [*5] ##1 !mem.wr;
   endsequence
   a_sp_forced_bits: assert property (sp[15:7] == 9'h003)
      else $error("pointer upper bits not forced");
   a_reset_top_value: assert property ($rose(rst_n) |-> sp == 16'h01ff)
      else $error("pointer not at top after reset");
   a_reinit_top: assert property (stack_reinit_op |=> sp == 16'h01ff)
      else $error("reinit did not reload pointer");
   a_push_next_free: assert property (
      mem.wr |-> mem.addr[6:0] == sp[6:0] + 7'h01)
      else $error("push address not the freed slot");
   a_access_in_stack: assert property (
      (mem.wr || mem.rd) |-> mem.addr[15:7] == 9'h003)
      else $error("stack access outside stack");
   a_int_five_bytes: assert property (s_go(CRS_OP_INT) |-> ##2 s_wr5)
      else $error("interrupt frame not five writes");
   a_call_two_bytes: assert property (
      s_go(CRS_OP_CALL) |-> ##2 mem.wr [*2] ##1 !mem.wr)
      else $error("call frame not two writes");
   a_iret_five_reads: assert property (
      s_go(CRS_OP_IRET) |-> ##2 mem.rd [*5] ##1 !mem.rd)
      else $error("interrupt return not five reads");
   a_int_low_first: assert property (s_go(CRS_OP_INT) |-> ##2
      (mem.addr == $past(sp, 2) &&
       mem.wdata == $past(regs.count_low_byte, 2)))
      else $error("first frame byte wrong");
   a_y_untouched: assert property (
      !(idx_we && prefix_sel) |=> $stable(regs.idx_y))
      else $error("second index changed without write");
   a_index_select: assert property (
      $stable(regs.idx_x) && $stable(regs.idx_y) |->
      idx_sel == ($past(prefix_sel) ? regs.idx_y : regs.idx_x))
      else $error("index selection wrong");
endmodule
bind crs_core_regs crs_checker chk (.ref_clk(ref_clk), .rst_n(rst_n),
   .stack_op(stack_op), .stack_reinit_op(stack_reinit_op), .idx_we(idx_we),
   .prefix_sel(prefix_sel), .regs(regs), .idx_sel(idx_sel), .mem(mem),
   .busy(busy));
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking bench for the core register set
`timescale 1ns/1ps
`default_nettype none
module testbench
   import crs_pkg::*;
;
   logic ref_clk = 1'b0, rst_n = 1'b0, stack_reinit_op = 1'b0;
   logic acc_we = 1'b0, idx_we = 1'b0, prefix_sel = 1'b0;
   logic pc_we = 1'b0, sp_low_we = 1'b0;
   crs_op_type stack_op = CRS_OP_NONE;
   logic [7:0] push_data = 8'h00, acc_wdata = 8'h00, idx_wdata = 8'h00;
   logic [7:0] sp_low_wdata = 8'h00, cc_in = 8'h00, got_pop, got_cc;
   logic [15:0] pc_wdata = 16'h0000;
   wire logic [7:0] mem_rdata, idx_sel, sp_low_byte, pop_data, cc_out;
   wire logic pop_valid, cc_valid, busy;
   wire crs_regs_type regs;
   wire crs_mem_type mem;
   int n_mismatch = 0, checks = 0;
   always #2 ref_clk = ~ref_clk;
   crs_core_regs uut (.ref_clk(ref_clk), .rst_n(rst_n), .stack_op(stack_op),
      .push_data(push_data), .stack_reinit_op(stack_reinit_op),
      .acc_we(acc_we), .acc_wdata(acc_wdata), .idx_we(idx_we),
      .prefix_sel(prefix_sel), .idx_wdata(idx_wdata), .pc_we(pc_we),
      .pc_wdata(pc_wdata), .sp_low_we(sp_low_we),
      .sp_low_wdata(sp_low_wdata), .cc_in(cc_in), .mem_rdata(mem_rdata),
      .regs(regs), .idx_sel(idx_sel), .sp_low_byte(sp_low_byte),
      .mem(mem), .pop_data(pop_data), .pop_valid(pop_valid),
      .cc_out(cc_out), .cc_valid(cc_valid), .busy(busy));
   crs_mem_model mdl (.ref_clk(ref_clk), .mem(mem), .mem_rdata(mem_rdata));
   //////////////////////////////////////////////////////////////////////////
   // verdict and comparison
   task automatic complete_run();
      if (n_mismatch == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one stack op pulse, then wait out the sequence
   task automatic run(input crs_op_type o, input logic [7:0] d);
      @(posedge ref_clk);
      stack_op <= o;
      push_data <= d;
      @(posedge ref_clk);
      stack_op <= CRS_OP_NONE;
      for (int i = 0; i < 12; i++) begin
         @(posedge ref_clk);
         if (pop_valid === 1'b1) got_pop = pop_data;
         if (cc_valid === 1'b1) got_cc = cc_out;
      end
   endtask
   // register port writes; leaves second index selected
   task automatic wr(input logic [7:0] a, x, y, input logic [15:0] pc);
      @(posedge ref_clk);
      {acc_we, idx_we, pc_we, prefix_sel} <= 4'b1110;
      {acc_wdata, idx_wdata, pc_wdata} <= {a, x, pc};
      @(posedge ref_clk);
      {acc_we, pc_we, prefix_sel, idx_wdata} <= {3'b001, y};
      @(posedge ref_clk);
      idx_we <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask
   task automatic sp_load(input logic [7:0] d);
      @(posedge ref_clk);
      {sp_low_we, sp_low_wdata} <= {1'b1, d};
      @(posedge ref_clk);
      sp_low_we <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask
   //////////////////////////////////////////////////////////////////////////
   // watchdog well beyond the expected run length
   initial begin
      #20000;
      n_mismatch++;
      complete_run();
   end
   // main sequence
   initial begin
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      cmp(regs.stack_top_pointer, 16'h01ff);
      wr(8'h5c, 8'h11, 8'h22, 16'h1234);
      cmp({regs.acc, regs.idx_x}, 16'h5c11);
      cmp({regs.count_high_byte, regs.count_low_byte}, 16'h1234);
      cmp({regs.idx_y, idx_sel}, 16'h2222);
      prefix_sel <= 1'b0;
      repeat (2) @(posedge ref_clk);
      cmp({idx_sel, regs.idx_y}, 16'h1122);
      run(CRS_OP_PUSH, 8'ha5);
      cmp({mdl.ram[9'h1ff], regs.stack_top_pointer[7:0]}, 16'ha5fe);
      run(CRS_OP_POP, 8'h00);
      cmp({got_pop, regs.stack_top_pointer[7:0]}, 16'ha5ff);
      sp_load(8'h00);
      cmp(regs.stack_top_pointer, 16'h0180);
      run(CRS_OP_PUSH, 8'h5a);
      cmp({mdl.ram[9'h180], regs.stack_top_pointer[7:0]}, 16'h5aff);
      run(CRS_OP_POP, 8'h00);
      cmp({got_pop, regs.stack_top_pointer[7:0]}, 16'h5a80);
      sp_load(8'hff);
      cmp({sp_low_byte, regs.stack_top_pointer[7:0]}, 16'hffff);
      cc_in <= 8'hc3;
      run(CRS_OP_INT, 8'h00);
      cmp(regs.stack_top_pointer, 16'h01fa);
      cmp({mdl.ram[9'h1ff], mdl.ram[9'h1fe]}, 16'h3412);
      cmp({mdl.ram[9'h1fd], mdl.ram[9'h1fc]}, 16'h115c);
      cmp({mdl.ram[9'h1fb], regs.idx_y}, 16'hc322);
      wr(8'h00, 8'h00, 8'h77, 16'hbeef);
      run(CRS_OP_IRET, 8'h00);
      cmp({regs.acc, regs.idx_x}, 16'h5c11);
      cmp({regs.count_high_byte, regs.count_low_byte}, 16'h1234);
      cmp({got_cc, regs.idx_y}, 16'hc377);
      cmp(regs.stack_top_pointer, 16'h01ff);
      wr(8'h5c, 8'h11, 8'h77, 16'h0a0b);
      run(CRS_OP_CALL, 8'h00);
      cmp({mdl.ram[9'h1ff], mdl.ram[9'h1fe]}, 16'h0b0a);
      cmp(regs.stack_top_pointer, 16'h01fd);
      wr(8'h00, 8'h00, 8'h77, 16'h0000);
      run(CRS_OP_RET, 8'h00);
      cmp({regs.count_high_byte, regs.count_low_byte}, 16'h0a0b);
      cmp(regs.stack_top_pointer, 16'h01ff);
      run(CRS_OP_PUSH, 8'h01);
      stack_reinit_op <= 1'b1;
      @(posedge ref_clk);
      stack_reinit_op <= 1'b0;
      @(posedge ref_clk);
      cmp(regs.stack_top_pointer, 16'h01ff);
      complete_run();
   end
endmodule
`default_nettype wire
